/* File: css_pkg.sv */
// Package for the conversion signal block: register map, field layout,
// encodings and timing constants. Assumes a 125 MHz internal clock.
package css_pkg;

    // One bit per conversion signal
    typedef struct packed {
        logic ft;
        logic cc2;
        logic cc1;
    } css_sig_s;

    typedef enum logic [1:0] {
        CSS_SEQ_IDLE,
        CSS_SEQ_ARMED,
        CSS_SEQ_RUN
    } css_seq_e;

    localparam int NUM_SIG = 3;
    localparam int NUM_SEQ = 2;
    localparam int SIG_CC1 = 0;
    localparam int SIG_CC2 = 1;
    localparam int SIG_FT  = 2;
    localparam int SEQ_ADC = 0;
    localparam int SEQ_DAC = 1;

    // Byte offsets on the register bus
    localparam logic [7:0] OFS_GEN_EN  = 8'h00;
    localparam logic [7:0] OFS_DRV     = 8'h04;
    localparam logic [7:0] OFS_SRC     = 8'h08;
    localparam logic [7:0] OFS_CC1_DIV = 8'h0C;
    localparam logic [7:0] OFS_CC2_DIV = 8'h10;
    localparam logic [7:0] OFS_FT_CFG  = 8'h14;
    localparam logic [7:0] OFS_SEQ     = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1C;

    // Two-bit route codes for driver and source selection
    localparam logic [1:0] ROUTE_NONE  = 2'h0;
    localparam logic [1:0] ROUTE_FRONT = 2'h1;
    localparam logic [1:0] ROUTE_BACK  = 2'h2;

    // Field positions
    localparam int FT_LOCK_BIT   = 16;
    localparam int SEQ_FIELD_W   = 8;
    localparam int SEQ_EN_BIT    = 0;
    localparam int SEQ_CSEL_BIT  = 1;
    localparam int SEQ_FRAME_BIT = 2;
    localparam int ST_SEL_LSB    = 3;
    localparam int ST_SEQ_LSB    = 8;

    // Reset values
    localparam logic [15:0] DIV_RST = 16'h0040;
    localparam logic [15:0] FLEN_RST = 16'h0001;

    // Timing
    localparam int CLK_PERIOD_NS    = 8;
    localparam int FT_MIN_WIDTH_NS  = 500;
    localparam int FT_MIN_SETUP_NS  = 250;
    localparam int FT_MIN_WIDTH_CYC =
        (FT_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FT_MIN_SETUP_CYC =
        (FT_MIN_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Half period that satisfies both pulse width and setup
    localparam int HALF_MIN_CYC = (FT_MIN_WIDTH_CYC > FT_MIN_SETUP_CYC) ?
        FT_MIN_WIDTH_CYC : FT_MIN_SETUP_CYC;

endpackage

/* File: css_top.sv */
// Conversion signal generation, selection and distribution: two conversion
// clocks and a frame trigger, paced ticks for the input and output sequencers.
// Assumes an AHB-Lite master on ref_clk and connector pins asynchronous to it.
//
// Operation
// [R01] Each sequencer paces on conversion clock one or two, as selected.
// [R02] Frame mode sequencers also use the frame trigger; others ignore it.
// [R03] Frame trigger aligns input and output frames when both use frame mode.
// [R04] Frame trigger generator is phase locked to generator one or two.
// [R05] Each signal sources from its own generator, front or back input.
// [R06] Generated signals may be driven out front or back.
// [R07] Master generates frame trigger and clock, drives them to all boards.
// [R08] Multi-board: every board, master too, uses the connector inputs.
// [R09] Frame mode sequencer waits for a frame trigger before converting.
// [R10] Single board: generators on, drivers off, internal sources.
// [R11] Master: generators on, drivers to a connector, connector sources.
// [R12] Target: generators and drivers off, connector sources.
// [R13] External frame trigger width 500ns up to half clock period.
// [R14] External frame trigger at least 250ns before next clock event.
// [R15] Clock event to next trigger at least half period minus 250ns.
// [R16] Front line one is clock one, line three clock two, line five trigger.
// [R17] External inputs are synchronised and edge detected into single pulses.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module css_top
#(
    parameter int DIV_W  = 16,
    parameter int FLEN_W = 16
)
(
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic                     hresp,
    input  wire css_pkg::css_sig_s   front_in,
    output css_pkg::css_sig_s        front_out,
    output css_pkg::css_sig_s        front_oe_n,
    input  wire css_pkg::css_sig_s   back_in,
    output css_pkg::css_sig_s        back_out,
    output css_pkg::css_sig_s        back_oe_n,
    output logic [1:0]               seq_tick,
    output logic [1:0]               seq_frame_start
);
    import css_pkg::*;

    // Registers
    logic [2:0]        gen_en_r;
    logic [5:0]        drv_r;
    logic [5:0]        src_r;
    logic [DIV_W-1:0]  div_r [2];
    logic [FLEN_W-1:0] flen_r;
    logic              ft_lock_r;
    logic [15:0]       seq_cfg_r;

    // Bus data phase state
    logic              wr_pend_r;
    logic [7:0]        wr_addr_r;
    logic [31:0]       rdata_r;

    // Generators
    logic [DIV_W-1:0]  div_cnt_r [2];
    logic [1:0]        gclk_r;
    logic [1:0]        gclk_prev_r;
    logic [FLEN_W-1:0] fcnt_r;
    logic              f_arm_r;
    logic              gft_r;

    // Pin synchronisers and selection
    css_sig_s          front_s1_r;
    css_sig_s          front_s2_r;
    css_sig_s          back_s1_r;
    css_sig_s          back_s2_r;
    logic [2:0]        sel_prev_r;
    css_sig_s          front_out_r;
    css_sig_s          front_oe_n_r;
    css_sig_s          back_out_r;
    css_sig_s          back_oe_n_r;

    // Sequencer gates
    css_seq_e          seq_st_r [2];
    logic [1:0]        tick_r;
    logic [1:0]        fstart_r;

    // Bus decode
    wire               addr_ok = hsel && hready && htrans[1];
    wire               wr_take = addr_ok && hwrite;
    wire               rd_take = addr_ok && !hwrite;
    wire [7:0]         rd_ofs  = {haddr[7:2], 2'b00};
    wire               in_range = (haddr[31:8] == 24'h00_0000);

    // Internal generator levels, one per signal
    wire [2:0]         gen_lvl = {gft_r, gclk_r};
    wire [2:0]         sel_lvl;
    wire [2:0]         sel_evt;
    wire [1:0]         gclk_rise = gclk_r & ~gclk_prev_r;
    wire [1:0]         gclk_fall = ~gclk_r & gclk_prev_r;
    wire               lock_rise = gclk_rise[ft_lock_r];
    wire               lock_fall = gclk_fall[ft_lock_r];
    wire [FLEN_W-1:0]  flen_last = (flen_r == '0) ? '0 : flen_r - 1'b1;
    wire [1:0]         seq_clk_evt;
    wire               ft_evt = sel_evt[SIG_FT];

    // Status word: generator levels, selected levels, sequencer states
    wire [31:0]        status_w = {20'h0_0000,
                                   2'(seq_st_r[SEQ_DAC]), 2'(seq_st_r[SEQ_ADC]),
                                   2'b00, sel_lvl, gen_lvl};

    logic [31:0]       rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (in_range)
        begin
            case (rd_ofs)
                OFS_GEN_EN:  rd_mux = {29'h0, gen_en_r};
                OFS_DRV:     rd_mux = {26'h0, drv_r};
                OFS_SRC:     rd_mux = {26'h0, src_r};
                OFS_CC1_DIV: rd_mux = 32'(div_r[SIG_CC1]);
                OFS_CC2_DIV: rd_mux = 32'(div_r[SIG_CC2]);
                OFS_FT_CFG:  rd_mux = 32'(flen_r) | (32'(ft_lock_r) << FT_LOCK_BIT);
                OFS_SEQ:     rd_mux = {16'h0000, seq_cfg_r};
                OFS_STATUS:  rd_mux = status_w;
                default:     rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Zero wait state slave; unmapped reads give zero, writes are dropped
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r   <= 32'h0000_0000;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= wr_take && in_range;
            wr_addr_r <= rd_ofs;
            if (rd_take)
                rdata_r <= rd_mux;
        end
    end
    assign hrdata = rdata_r;

    // Configuration writes; reset leaves a quiet single-board setup
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            gen_en_r  <= 3'b000;
            drv_r     <= {3{ROUTE_NONE}};
            src_r     <= {3{ROUTE_NONE}};
            flen_r    <= FLEN_W'(FLEN_RST);
            ft_lock_r <= 1'b0;
            seq_cfg_r <= 16'h0000;
        end
        else if (wr_pend_r)
        begin
            case (wr_addr_r)
                OFS_GEN_EN: gen_en_r <= hwdata[2:0]; // [R10] [R11] [R12]
                OFS_DRV:    drv_r    <= hwdata[5:0]; // [R11] [R12]
                OFS_SRC:    src_r    <= hwdata[5:0]; // [R08] [R11] [R12]
                OFS_FT_CFG:
                begin
                    flen_r    <= hwdata[FLEN_W-1:0];
                    ft_lock_r <= hwdata[FT_LOCK_BIT];
                end
                OFS_SEQ:    seq_cfg_r <= hwdata[15:0];
                default:    ;
            endcase
        end
    end

    // Conversion clock generators: square wave, half period from divider
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_gen
            wire [DIV_W-1:0] half = (div_r[gi] < DIV_W'(HALF_MIN_CYC)) ?
                                    DIV_W'(HALF_MIN_CYC) - 1'b1 : div_r[gi] - 1'b1;
            wire             wr_div = wr_pend_r &&
                                      (wr_addr_r == (gi == 0 ? OFS_CC1_DIV : OFS_CC2_DIV));

            always_ff @(posedge ref_clk)
            begin
                if (!resetn)
                    div_r[gi] <= DIV_W'(DIV_RST);
                else if (wr_div)
                    div_r[gi] <= hwdata[DIV_W-1:0];
            end

            always_ff @(posedge ref_clk)
            begin
                if (!resetn || !gen_en_r[gi])
                begin
                    div_cnt_r[gi] <= '0;
                    gclk_r[gi]    <= 1'b0;
                end
                else if (div_cnt_r[gi] >= half)
                begin
                    div_cnt_r[gi] <= '0;
                    gclk_r[gi]    <= ~gclk_r[gi];
                end
                else
                    div_cnt_r[gi] <= div_cnt_r[gi] + 1'b1;
            end
        end
    endgenerate

    // Frame trigger generator: rises on a falling edge of the locked clock
    // and falls on its next rising edge, so setup and width are each half
    // a clock period, never under the minimum half period.
    always_ff @(posedge ref_clk)
    begin
        if (!resetn || !gen_en_r[SIG_FT])
        begin
            gclk_prev_r <= 2'b00;
            fcnt_r      <= '0;
            f_arm_r     <= 1'b0;
            gft_r       <= 1'b0;
        end
        else
        begin
            gclk_prev_r <= gclk_r;
            if (lock_rise) // [R04]
            begin
                gft_r <= 1'b0;
                if (fcnt_r >= flen_last)
                begin
                    fcnt_r  <= '0;
                    f_arm_r <= 1'b1;
                end
                else
                    fcnt_r <= fcnt_r + 1'b1;
            end
            else if (lock_fall && f_arm_r) // [R04]
            begin
                gft_r   <= 1'b1;
                f_arm_r <= 1'b0;
            end
        end
    end

    // Connector inputs: two flip-flops before any use
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            front_s1_r <= '0;
            front_s2_r <= '0;
            back_s1_r  <= '0;
            back_s2_r  <= '0;
            sel_prev_r <= 3'b000;
        end
        else
        begin
            front_s1_r <= front_in; // [R17]
            front_s2_r <= front_s1_r;
            back_s1_r  <= back_in;
            back_s2_r  <= back_s1_r;
            sel_prev_r <= sel_lvl;
        end
    end

    // Per signal: source select, rising edge event, output driver
    genvar si;
    generate
        for (si = 0; si < NUM_SIG; si++)
        begin : g_sig
            wire [1:0] src = src_r[2*si +: 2];
            wire [1:0] drv = drv_r[2*si +: 2];
            wire       on  = gen_en_r[si];

            // A master loops its own driven signal back through the pins
            assign sel_lvl[si] = (src == ROUTE_FRONT) ? front_s2_r[si] : // [R05] [R08]
                                 (src == ROUTE_BACK)  ? back_s2_r[si]  :
                                 gen_lvl[si];
            assign sel_evt[si] = sel_lvl[si] && !sel_prev_r[si]; // [R17]

            always_ff @(posedge ref_clk)
            begin
                if (!resetn)
                begin
                    front_out_r[si]  <= 1'b0;
                    front_oe_n_r[si] <= 1'b1;
                    back_out_r[si]   <= 1'b0;
                    back_oe_n_r[si]  <= 1'b1;
                end
                else
                begin
                    // Front lines one, three and five carry cc1, cc2, ft
                    front_out_r[si]  <= gen_lvl[si]; // [R16]
                    front_oe_n_r[si] <= !(on && drv == ROUTE_FRONT); // [R06] [R07]
                    back_out_r[si]   <= gen_lvl[si];
                    back_oe_n_r[si]  <= !(on && drv == ROUTE_BACK); // [R06] [R07]
                end
            end
        end
    endgenerate

    assign front_out  = front_out_r;
    assign front_oe_n = front_oe_n_r;
    assign back_out   = back_out_r;
    assign back_oe_n  = back_oe_n_r;

    // Sequencer gates: 0 input side, 1 output side
    genvar qi;
    generate
        for (qi = 0; qi < NUM_SEQ; qi++)
        begin : g_seq
            wire [7:0] cfg   = seq_cfg_r[SEQ_FIELD_W*qi +: SEQ_FIELD_W];
            wire       en    = cfg[SEQ_EN_BIT];
            wire       frame = cfg[SEQ_FRAME_BIT];
            css_seq_e  st_nxt;

            assign seq_clk_evt[qi] = cfg[SEQ_CSEL_BIT] ? sel_evt[SIG_CC2] // [R01]
                                                       : sel_evt[SIG_CC1];

            always_comb
            begin
                st_nxt = seq_st_r[qi];
                case (seq_st_r[qi])
                    CSS_SEQ_IDLE:
                        if (en)
                            st_nxt = frame ? CSS_SEQ_ARMED : CSS_SEQ_RUN; // [R02]
                    CSS_SEQ_ARMED:
                        if (!en)
                            st_nxt = CSS_SEQ_IDLE;
                        else if (ft_evt) // [R09]
                            st_nxt = CSS_SEQ_RUN;
                    CSS_SEQ_RUN:
                        if (!en)
                            st_nxt = CSS_SEQ_IDLE;
                    default:
                        st_nxt = CSS_SEQ_IDLE;
                endcase
            end

            always_ff @(posedge ref_clk)
            begin
                if (!resetn)
                begin
                    seq_st_r[qi] <= CSS_SEQ_IDLE;
                    tick_r[qi]   <= 1'b0;
                    fstart_r[qi] <= 1'b0;
                end
                else
                begin
                    seq_st_r[qi] <= st_nxt;
                    // No tick while armed: conversion starts after the trigger
                    tick_r[qi]   <= (seq_st_r[qi] == CSS_SEQ_RUN) && en &&
                                    seq_clk_evt[qi]; // [R01] [R09]
                    // Both sides see the same trigger, so frames line up
                    fstart_r[qi] <= en && frame && ft_evt && // [R02] [R03]
                                    (seq_st_r[qi] != CSS_SEQ_IDLE);
                end
            end
        end
    endgenerate

    assign seq_tick        = tick_r;
    assign seq_frame_start = fstart_r;

endmodule // css_top

/* File: css_top_assertions.sv */
// Checker for the conversion signal block: bus answer, pulse shapes, drivers.
// Assumes it sees only the css_top ports, attached by the bind at the foot.
`timescale 1ns/1ns
module css_top_assertions
(
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    input  wire logic              hreadyout,
    input  wire logic [31:0]       hrdata,
    input  wire logic              hresp,
    input  wire css_pkg::css_sig_s front_oe_n,
    input  wire css_pkg::css_sig_s back_oe_n,
    input  wire logic [1:0]        seq_tick,
    input  wire logic [1:0]        seq_frame_start
);
    import css_pkg::*;
    logic take;
    assign take = hsel && hready && htrans[1];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence wr_at(logic [7:0] a);
        take && hwrite && haddr == 32'(a);
    endsequence

    bus_ready_a: assert property (hreadyout)
        else $error("hreadyout low");
    bus_okay_a: assert property (!hresp)
        else $error("error response");
    reset_quiet_a: assert property ($rose(resetn) |-> seq_tick == 2'b00 &&
        (front_oe_n & back_oe_n) == 3'h7 && hrdata == 32'h0000_0000)
        else $error("outputs not quiet after reset");
    rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (take && !hwrite && haddr >= 32'h0000_0020
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    tick_pulse_a: assert property ((seq_tick & $past(seq_tick)) == 2'b00)
        else $error("tick longer than one cycle");
    frame_pulse_a: assert property (|seq_frame_start
        |=> (seq_frame_start == 2'b00)[*8])
        else $error("frame start not a lone pulse");
    oe_single_a: assert property ((front_oe_n | back_oe_n) == 3'h7)
        else $error("signal driven on both connectors");
    gen_off_a: assert property (wr_at(OFS_GEN_EN) ##1 hwdata[2:0] == 3'h0
        |-> ##[1:3] (front_oe_n & back_oe_n) == 3'h7)
        else $error("driver on without generator");
    seq_stop_a: assert property (wr_at(OFS_SEQ) ##1 hwdata == 32'h0000_0000
        |-> ##6 (seq_tick == 2'b00 && seq_frame_start == 2'b00)[*8])
        else $error("pulses after sequencers disabled");
endmodule // css_top_assertions

bind css_top css_top_assertions chk (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .front_oe_n(front_oe_n),
    .back_oe_n(back_oe_n), .seq_tick(seq_tick), .seq_frame_start(seq_frame_start));

/* File: css_peer.sv */
// Far-side master board model: global conversion clocks and frame trigger.
// Assumes the bench routes its lines to one connector and gates it by run.
`timescale 1ns/1ns
module css_peer
#(
    parameter int CC1_HALF_NS = 600,
    parameter int CC2_HALF_NS = 40,
    parameter int FT_WIDTH_NS = 500
)
(
    input  wire logic         run,
    output css_pkg::css_sig_s sig
);
    import css_pkg::*;
    // Lines stand still low outside a run, as an idle master leaves them
    initial sig = '0;
    always
    begin
        wait (run);
        sig.cc1 = 1'b1;
        #CC1_HALF_NS;
        sig.cc1 = 1'b0;
        #CC1_HALF_NS;
    end
    always
    begin
        wait (run);
        sig.cc2 = 1'b1;
        #CC2_HALF_NS;
        sig.cc2 = 1'b0;
        #CC2_HALF_NS;
    end
    // Rising on the clock's fall leaves a half period of setup and hold;
    // the power-up fall of cc1 outside a run must not raise a trigger
    always @(negedge sig.cc1)
    begin
        sig.ft = (run === 1'b1);
        #FT_WIDTH_NS;
        sig.ft = 1'b0;
    end
endmodule // css_peer

/* File: css_top_test.sv */
// Self-checking bench for css_top: AHB-Lite register tasks and board setups.
// Assumes css_peer as the far board and a 125 MHz ref_clk.
`timescale 1ns/1ns
module css_top_test;
    import css_pkg::*;
    logic        ref_clk;
    logic        resetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    css_sig_s    front_in;
    css_sig_s    front_out;
    css_sig_s    front_oe_n;
    css_sig_s    back_in;
    css_sig_s    back_out;
    css_sig_s    back_oe_n;
    logic [1:0]  seq_tick;
    logic [1:0]  seq_frame_start;
    css_sig_s    peer_sig;
    logic        peer_run;
    logic        peer_front;
    logic [2:0]  flt;
    logic [31:0] q;
    int          errors;
    int          checked;
    int          n[4];

    css_top dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .front_in(front_in), .front_out(front_out), .front_oe_n(front_oe_n),
        .back_in(back_in), .back_out(back_out), .back_oe_n(back_oe_n),
        .seq_tick(seq_tick), .seq_frame_start(seq_frame_start));
    css_peer peer (.run(peer_run), .sig(peer_sig));

    always #4 ref_clk = ~ref_clk;
    // Undriven lines toggle every cycle, so a wrong source shows at once
    always @(posedge ref_clk) flt <= ~flt;
    assign front_in = (~front_oe_n & front_out) | (front_oe_n & (peer_front ? peer_sig : flt));
    assign back_in = (~back_oe_n & back_out) | (back_oe_n & (peer_front ? flt : peer_sig));

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rng4(input int lo[4], input int hi[4]);
        for (int i = 0; i < 4; i++)
        begin
            checked++;
            if (n[i] < lo[i] || n[i] > hi[i])
            begin
                errors++;
                $display("Error count %0d expected %0d to %0d seen %0d", i, lo[i], hi[i], n[i]);
            end
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        for (int p = 0; p < 2; p++)
        begin
            do
                @(posedge ref_clk);
            while (hreadyout !== 1'b1);
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= d;
        end
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        cmp($sformatf("register %h", a), e, q);
    endtask

    task automatic seq_set(input logic [31:0] v);
        wr(OFS_SEQ, 32'h0000_0000);
        repeat (16) @(posedge ref_clk);
        rdc(OFS_SEQ, 32'h0000_0000);
        wr(OFS_SEQ, v);
    endtask

    // Counts ticks and frame starts; a frame-mode tick before its frame is an error
    task automatic watch(input int cyc, input logic [1:0] fm);
        int first[2];
        n = '{0, 0, 0, 0};
        first = '{-1, -1};
        for (int c = 0; c < cyc; c++)
        begin
            @(posedge ref_clk);
            for (int i = 0; i < 2; i++)
            begin
                if (seq_frame_start[i] === 1'b1)
                begin
                    if (n[2 + i] == 0)
                        first[i] = c;
                    n[2 + i]++;
                end
                if (seq_tick[i] === 1'b1)
                begin
                    n[i]++;
                    if (fm[i] && n[2 + i] == 0)
                        cmp("tick before frame", 0, 1);
                end
            end
        end
        if (fm == 2'b11)
            cmp("frame align", first[0], first[1]);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge ref_clk);
        errors++;
        conclude();
    end

    initial
    begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        flt = 3'h0;
        peer_run = 1'b0;
        peer_front = 1'b1;
        errors = 0;
        checked = 0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rdc(i * 4, (i == 3 || i == 4) ? 32'h0000_0040 : 32'(i == 5));
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        wr(32'h0000_0020, 32'hFFFF_FFFF);
        rdc(OFS_STATUS, 32'h0000_0000);
        rdc(32'h0000_0020, 32'h0000_0000);
        wr(OFS_GEN_EN, 32'h0000_0007);
        wr(OFS_CC1_DIV, 32'h0000_003F);
        wr(OFS_CC2_DIV, 32'h0000_0064);
        wr(OFS_DRV, 32'hFFFF_FF00);
        rdc(OFS_DRV, 32'h0000_0000);
        rdc(OFS_CC1_DIV, 32'h0000_003F);
        rdc(32'h0000_0100, 32'h0000_0000);
        seq_set(32'h0000_0701);
        watch(2520, 2'b10);
        rng4('{19, 11, 0, 19}, '{21, 13, 0, 21});
        cmp("front oe", 3'h7, front_oe_n);
        wr(OFS_FT_CFG, 32'h0001_0002);
        rdc(OFS_FT_CFG, 32'h0001_0002);
        watch(2520, 2'b00);
        rng4('{19, 11, 0, 5}, '{21, 13, 0, 7});
        for (int c = 0; c < 4; c++)
        begin
            wr(OFS_DRV, 32'(c * 21));
            repeat (4) @(posedge ref_clk);
            cmp("front oe", (c == 1) ? 3'h0 : 3'h7, front_oe_n);
            cmp("back oe", (c == 2) ? 3'h0 : 3'h7, back_oe_n);
        end
        wr(OFS_GEN_EN, 32'h0000_0000);
        wr(OFS_DRV, 32'h0000_0015);
        repeat (4) @(posedge ref_clk);
        cmp("oe off", 3'h7, front_oe_n & back_oe_n);
        cmp("outs off", 32'h0000_0000, {front_out, back_out});
        wr(OFS_SRC, 32'h0000_0015);
        @(posedge ref_clk);
        #3;
        peer_run = 1'b1;
        for (int b = 0; b < 2; b++)
        begin
            seq_set(32'h0000_0705);
            watch(1500, 2'b11);
            rng4('{8, 135, 9, 9}, '{11, 151, 11, 11});
            // Stop the sequencers first: a source swap passes toggling idle lines
            wr(OFS_SEQ, 32'h0000_0000);
            @(posedge ref_clk);
            peer_front <= 1'b0;
            wr(OFS_SRC, 32'h0000_002A);
        end
        peer_run = 1'b0;
        repeat (200) @(posedge ref_clk);
        peer_front <= 1'b1;
        wr(OFS_GEN_EN, 32'h0000_0007);
        wr(OFS_SRC, 32'h0000_0015);
        wr(OFS_FT_CFG, 32'h0000_0001);
        seq_set(32'h0000_0705);
        watch(2520, 2'b11);
        rng4('{18, 11, 19, 19}, '{21, 13, 21, 21});
        cmp("master front oe", 3'h0, front_oe_n);
        conclude();
    end
endmodule // css_top_test
